// *** hw/cmpc_event.sv ***
`timescale 1ns/10ps
// Edge / toggle detector on the synchronised result
module cmpc_event (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic                   res_i,
    input  wire cmpc_pkg::cmpc_mode_type mode_i,
    output logic                        pulse_o
);
    logic prev_r;

    // Result one clock earlier
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r <= 1'b0;
        end else if (ce_i) begin
            prev_r <= res_i;
        end
    end

    // Mode decode; reserved code gives no event
    always_comb begin
        unique case (mode_i)
            cmpc_pkg::CMPC_EV_TOGGLE:   pulse_o = res_i ^ prev_r;
            cmpc_pkg::CMPC_EV_RESERVED: pulse_o = 1'b0;
            cmpc_pkg::CMPC_EV_FALL:     pulse_o = prev_r & ~res_i;
            cmpc_pkg::CMPC_EV_RISE:     pulse_o = ~prev_r & res_i;
        endcase
    end
endmodule // cmpc_event

// *** hw/cmpc_pkg.sv ***
package cmpc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CMP_CTRL_STATUS_OFFS   = 8'h50;
    localparam logic [7:0] CONV_CTRL_STATUS_B_OFFS = 8'h7b;
    localparam logic [7:0] PIN_INPUT_DISABLE_OFFS  = 8'h7f;
    localparam logic [7:0] CONV_CONTROL_OFFS       = 8'h7a;
    localparam logic [7:0] CONV_MUX_OFFS           = 8'h7c;
    localparam logic [7:0] POWER_GATE_OFFS         = 8'h64;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POWER_OFF_BIT     = 7;
    localparam int REF_SELECT_BIT    = 6;
    localparam int RESULT_BIT        = 5;
    localparam int EVENT_FLAG_BIT    = 4;
    localparam int IRQ_ENABLE_BIT    = 3;
    localparam int CAPTURE_ROUTE_BIT = 2;
    localparam int MUX_SELECT_EN_BIT = 6;
    localparam int CONV_ENABLE_BIT   = 7;
    localparam int CONV_POWER_GATE_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CMP_CTRL_RESET   = 8'h00;
    localparam logic [7:0] CONV_B_RESET     = 8'h00;
    localparam logic [1:0] PIN_DIS_RESET    = 2'h0;
    localparam logic [2:0] CHAN_SEL_RESET   = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMPC_EV_TOGGLE   = 2'h0,
        CMPC_EV_RESERVED = 2'h1,
        CMPC_EV_FALL     = 2'h2,
        CMPC_EV_RISE     = 2'h3
    } cmpc_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmpc_bus_type;

endpackage

// *** hw/cmpc_sync.sv ***
`timescale 1ns/10ps
// Two-flop synchroniser; the first stage feeds only the second
module cmpc_sync (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    // --------------------------------------------------------
    // Sync stages
    // --------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else if (ce_i) begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule // cmpc_sync

// *** hw/cmpc_top.sv ***
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
// What this block does
// - Raw result high when positive exceeds negative
// - Channel pin negative when mux enabled, converter off and ungated
// - Bit 6 selects bandgap as positive input
// - Result synchronised, one to two cycles
// - Bit 7 powers comparator off
// - Event flag set on matching transition
// - Flag cleared by vector or writing one
// - Interrupt when flag, enable, global enable
// - Mode 00 toggle, 10 fall, 11 rise
// - Bit 2 routes result to capture
// - Pin buffer disable forces input zero
// - Converter enable owns mux, denies comparator
module cmpc_top (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    // Analog front end (abstracted as a compare result)
    input  wire logic       analog_gt_i,
    output logic            analog_power_on_o,
    output logic            pos_ref_select_o,
    output logic            neg_use_channel_o,
    output logic [2:0]      neg_channel_o,
    // Digital pin inputs of the two comparator pins
    input  wire logic [1:0] pin_digital_i,
    output logic [1:0]      pin_buffer_enable_o,
    output logic [1:0]      pin_read_o,
    // System
    input  wire logic       global_irq_enable_i,
    input  wire logic       irq_ack_i,
    output logic            irq_o,
    output logic            capture_in_o,
    output logic            capture_valid_o
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic       power_off_r;
    logic       ref_select_r;
    logic       event_flag_r;
    logic       irq_enable_r;
    logic       capture_route_r;
    cmpc_pkg::cmpc_mode_type mode_r;
    logic       mux_select_en_r;
    logic [3:0] conv_b_low_r;
    logic [1:0] pin_dis_r;
    logic       conv_enable_r;
    logic [2:0] chan_sel_r;
    logic       power_gate_r;
    logic       raw_res;
    logic       sync_res;
    logic       ev_pulse;
    logic [1:0] pin_sync;
    logic [7:0] rdata_nxt;
    cmpc_pkg::cmpc_bus_type bus;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ------------------------------------------------------------
    // Control register writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            power_off_r     <= 1'b0;
            ref_select_r    <= 1'b0;
            irq_enable_r    <= 1'b0;
            capture_route_r <= 1'b0;
            mode_r          <= cmpc_pkg::CMPC_EV_TOGGLE;
        end else if (ce_i && bus.wr && bus.addr == cmpc_pkg::CMP_CTRL_STATUS_OFFS) begin
            power_off_r     <= bus.wdata[cmpc_pkg::POWER_OFF_BIT];
            ref_select_r    <= bus.wdata[cmpc_pkg::REF_SELECT_BIT];
            irq_enable_r    <= bus.wdata[cmpc_pkg::IRQ_ENABLE_BIT];
            capture_route_r <= bus.wdata[cmpc_pkg::CAPTURE_ROUTE_BIT];
            mode_r          <= cmpc_pkg::cmpc_mode_type'(bus.wdata[1:0]);
        end
    end

    // Converter side registers, also reachable from here
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mux_select_en_r <= 1'b0;
            conv_b_low_r    <= 4'h0;
            pin_dis_r       <= cmpc_pkg::PIN_DIS_RESET;
            conv_enable_r   <= 1'b0;
            chan_sel_r      <= cmpc_pkg::CHAN_SEL_RESET;
            power_gate_r    <= 1'b0;
        end else if (ce_i && bus.wr) begin
            unique case (bus.addr)
                cmpc_pkg::CONV_CTRL_STATUS_B_OFFS: begin
                    mux_select_en_r <= bus.wdata[cmpc_pkg::MUX_SELECT_EN_BIT];
                    conv_b_low_r    <= bus.wdata[3:0];
                end
                cmpc_pkg::PIN_INPUT_DISABLE_OFFS: pin_dis_r <= bus.wdata[1:0];
                cmpc_pkg::CONV_CONTROL_OFFS: conv_enable_r <= bus.wdata[cmpc_pkg::CONV_ENABLE_BIT];
                cmpc_pkg::CONV_MUX_OFFS: chan_sel_r <= bus.wdata[2:0];
                cmpc_pkg::POWER_GATE_OFFS: power_gate_r <= bus.wdata[cmpc_pkg::CONV_POWER_GATE_BIT];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Analog steering
    // ------------------------------------------------------------
    // The mux is only lent out while the converter is off and ungated
    assign neg_use_channel_o = mux_select_en_r & ~conv_enable_r & ~power_gate_r;
    assign neg_channel_o     = chan_sel_r;
    assign pos_ref_select_o  = ref_select_r;
    assign analog_power_on_o = ~power_off_r;
    // Powered-off comparator presents a steady low result
    assign raw_res = analog_gt_i & ~power_off_r;

    // ------------------------------------------------------------
    // Result synchroniser and event detection
    // ------------------------------------------------------------
    cmpc_sync u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .d_i    (raw_res),
        .q_o    (sync_res)
    );

    cmpc_event u_event (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .res_i   (sync_res),
        .mode_i  (mode_r),
        .pulse_o (ev_pulse)
    );

    // Event flag: a new event wins over any clear in the same cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            event_flag_r <= 1'b0;
        end else if (ce_i) begin
            if (ev_pulse) begin
                event_flag_r <= 1'b1;
            end else if (irq_ack_i) begin
                event_flag_r <= 1'b0;
            end else if (bus.wr && bus.addr == cmpc_pkg::CMP_CTRL_STATUS_OFFS
                         && bus.wdata[cmpc_pkg::EVENT_FLAG_BIT]) begin
                event_flag_r <= 1'b0;
            end
        end
    end

    // Irq request is a level; mode or power changes with irq on may fire it
    assign irq_o = event_flag_r & irq_enable_r & global_irq_enable_i;

    // ------------------------------------------------------------
    // Capture routing
    // ------------------------------------------------------------
    assign capture_in_o    = capture_route_r & sync_res;
    assign capture_valid_o = capture_route_r;

    // ------------------------------------------------------------
    // Pin input path
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            cmpc_sync u_pin_sync (
                .mclk_i (mclk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .d_i    (pin_digital_i[gi]),
                .q_o    (pin_sync[gi])
            );
            assign pin_buffer_enable_o[gi] = ~pin_dis_r[gi];
            assign pin_read_o[gi]          = pin_sync[gi] & ~pin_dis_r[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path, data in the cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (bus.addr)
            cmpc_pkg::CMP_CTRL_STATUS_OFFS:
                rdata_nxt = {power_off_r, ref_select_r, sync_res, event_flag_r,
                             irq_enable_r, capture_route_r, mode_r};
            cmpc_pkg::CONV_CTRL_STATUS_B_OFFS:
                rdata_nxt = {1'b0, mux_select_en_r, 2'b00, conv_b_low_r};
            cmpc_pkg::PIN_INPUT_DISABLE_OFFS:
                rdata_nxt = {6'h00, pin_dis_r};
            cmpc_pkg::CONV_CONTROL_OFFS:
                rdata_nxt = {conv_enable_r, 7'h00};
            cmpc_pkg::CONV_MUX_OFFS:
                rdata_nxt = {5'h00, chan_sel_r};
            cmpc_pkg::POWER_GATE_OFFS:
                rdata_nxt = {7'h00, power_gate_r};
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    // Read data register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= bus.rd ? rdata_nxt : 8'h00;
        end
    end

endmodule // cmpc_top

// *** verif/cmpc_analog_model.sv ***
`timescale 1ns/10ps
// --------------------------
// Analog front end model
// --------------------------
module cmpc_analog_model (
    input  wire logic       power_on_i,
    input  wire logic       ref_sel_i,
    input  wire logic       use_chan_i,
    input  wire logic [2:0] chan_i,
    input  wire logic [7:0] pos_mv_i,
    input  wire logic [7:0] neg_mv_i,
    input  wire logic [7:0] bg_mv_i,
    input  wire logic [7:0] chan_mv_i [8],
    output logic            gt_o
);
    logic [7:0] p;
    logic [7:0] n;
    // Choose both inputs; an unpowered comparator reports low
    always_comb begin
        p = ref_sel_i ? bg_mv_i : pos_mv_i;
        n = use_chan_i ? chan_mv_i[chan_i] : neg_mv_i;
        gt_o = power_on_i && (p > n);
    end
endmodule // cmpc_analog_model

// *** verif/cmpc_properties.sv ***
`timescale 1ns/10ps
// --------------------------
// Port checker
// --------------------------
module cmpc_properties (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       analog_gt_i,
    input wire logic       analog_power_on_o,
    input wire logic       pos_ref_select_o,
    input wire logic       neg_use_channel_o,
    input wire logic [2:0] neg_channel_o,
    input wire logic [1:0] pin_buffer_enable_o,
    input wire logic [1:0] pin_read_o,
    input wire logic       global_irq_enable_i,
    input wire logic       irq_ack_i,
    input wire logic       irq_o,
    input wire logic       capture_in_o,
    input wire logic       capture_valid_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // Decoded writes to the registers watched here
    logic w50, w7a, w7b, w7c;
    assign w50 = wr_i && addr_i == cmpc_pkg::CMP_CTRL_STATUS_OFFS;
    assign w7a = wr_i && addr_i == cmpc_pkg::CONV_CONTROL_OFFS;
    assign w7b = wr_i && addr_i == cmpc_pkg::CONV_CTRL_STATUS_B_OFFS;
    assign w7c = wr_i && addr_i == cmpc_pkg::CONV_MUX_OFFS;
    // Input held long enough to cross both flops
    sequence s_gt_hi;
        (analog_gt_i && analog_power_on_o)[*3];
    endsequence
    // No input or power change that could still be in flight; either one can raise a fresh event
    sequence s_quiet;
        ($stable(analog_gt_i) && $stable(analog_power_on_o))[*6];
    endsequence
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    AST_POWER: assert property (w50 |=> analog_power_on_o == !$past(wdata_i[7])) else $error("power bit");
    AST_REF_SEL: assert property (w50 |=> pos_ref_select_o == $past(wdata_i[6])) else $error("ref select");
    AST_CHAN: assert property (w7c |=> neg_channel_o == $past(wdata_i[2:0])) else $error("channel");
    AST_NEG_PIN: assert property ((w7b && !wdata_i[6]) || (w7a && wdata_i[7]) |=> !neg_use_channel_o)
        else $error("negative pin not used");
    AST_SYNC_HI: assert property (s_gt_hi ##0 capture_valid_o |-> capture_in_o) else $error("sync late");
    AST_ROUTE_OFF: assert property (!capture_valid_o |-> !capture_in_o) else $error("capture leak");
    AST_PIN_OFF: assert property ((pin_read_o & ~pin_buffer_enable_o) == 2'h0) else $error("pin read");
    AST_IRQ_GLOBAL: assert property (!global_irq_enable_i |-> !irq_o) else $error("irq masked");
    AST_ACK: assert property (s_quiet ##0 irq_ack_i |=> !irq_o) else $error("ack kept irq");
endmodule // cmpc_properties

// *** verif/cmpc_top_tb.sv ***
`timescale 1ns/10ps
// --------------------------
// Bench top
// --------------------------
module cmpc_top_tb;
    logic       mclk_i, rst_i, wr_i, rd_i, gt, gie, ack, pwr, rsel, usech, cin, cval, irq, ce;
    logic [7:0] addr_i, wdata_i, rdata_o, pos_mv, v;
    logic [7:0] chan_mv [8];
    logic [1:0] pins, ben, prd;
    logic [2:0] chan;
    int         mismatches, n_tests;
    cmpc_top u_dut (.mclk_i, .rst_i, .ce_i(ce), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .analog_gt_i(gt),
        .analog_power_on_o(pwr), .pos_ref_select_o(rsel), .neg_use_channel_o(usech), .neg_channel_o(chan),
        .pin_digital_i(pins), .pin_buffer_enable_o(ben), .pin_read_o(prd), .global_irq_enable_i(gie),
        .irq_ack_i(ack), .irq_o(irq), .capture_in_o(cin), .capture_valid_o(cval));
    cmpc_analog_model u_am (.power_on_i(pwr), .ref_sel_i(rsel), .use_chan_i(usech), .chan_i(chan),
        .pos_mv_i(pos_mv), .neg_mv_i(8'h32), .bg_mv_i(8'h1e), .chan_mv_i(chan_mv), .gt_o(gt));
    // Clock
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits settle past the edge so outputs are read after they land
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog against a hung sequence
    initial begin
        #20000;
        mismatches++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        {mismatches, n_tests} = '0;
        {addr_i, wdata_i, wr_i, rd_i, ack, pos_mv} = '0;
        gie = 1'b1;
        ce = 1'b1;
        pins = 2'h3;
        rst_i = 1'b1;
        for (int i = 0; i < 8; i++)
            chan_mv[i] = 8'(i * 8'h1e);
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        tick(3);
        chk(8'(ben), 8'h03);
        chk(8'(pwr), 8'h01);
        chk(8'(prd), 8'h03);
        rd(8'h50, v); chk(v, 8'h00);
        rd(8'h7b, v); chk(v, 8'h00);
        rd(8'h33, v); chk(v, 8'h00);
        wr(8'h7f, 8'h03); tick(1); chk(8'({ben, prd}), 8'h00);
        // Clock enable low: this write must not land
        ce <= 1'b0;
        wr(8'h7f, 8'h00);
        ce <= 1'b1;
        rd(8'h7f, v); chk(v, 8'h03);
        // One pin disabled, the other passes a real high level
        pins <= 2'h1;
        wr(8'h7f, 8'h02); tick(2); chk(8'({ben, prd}), 8'h05);
        pos_mv <= 8'h64; tick(4);
        rd(8'h50, v); chk(v, 8'h30);
        wr(8'h50, 8'h50); tick(4);
        rd(8'h50, v); chk(v, 8'h50);
        wr(8'h50, 8'h10);
        wr(8'h64, 8'h00); wr(8'h7a, 8'h00); wr(8'h7b, 8'h40);
        for (int i = 0; i < 8; i++) begin
            wr(8'h7c, 8'(i)); tick(3);
            chk(8'({usech, chan}), 8'(8 + i));
            rd(8'h50, v); chk(v & 8'h20, (i < 4) ? 8'h20 : 8'h00);
        end
        wr(8'h64, 8'h01); tick(1); chk(8'(usech), 8'h00);
        wr(8'h64, 8'h00); wr(8'h7a, 8'h80); tick(4); chk(8'(usech), 8'h00);
        rd(8'h50, v); chk(v & 8'h20, 8'h20);
        wr(8'h7b, 8'h00);
        // Interrupt off while the mode changes, so no stray request
        for (int m = 0; m < 4; m++) begin
            wr(8'h50, 8'(m));
            wr(8'h50, 8'(8'h18 | m));
            pos_mv <= 8'h00; tick(8);
            chk(8'(irq), (m == 0 || m == 2) ? 8'h01 : 8'h00);
            ack <= 1'b1; tick(1);
            ack <= 1'b0;
            chk(8'(irq), 8'h00);
            pos_mv <= 8'h64; tick(8);
            chk(8'(irq), (m == 0 || m == 3) ? 8'h01 : 8'h00);
            wr(8'h50, 8'(8'h18 | m)); tick(1); chk(8'(irq), 8'h00);
        end
        wr(8'h50, 8'h00); wr(8'h50, 8'h18);
        gie <= 1'b0;
        pos_mv <= 8'h00; tick(8); chk(8'(irq), 8'h00);
        gie <= 1'b1; tick(1); chk(8'(irq), 8'h01);
        wr(8'h50, 8'h10); wr(8'h50, 8'h04);
        pos_mv <= 8'h64; tick(4); chk(8'({cval, cin}), 8'h03);
        wr(8'h50, 8'h84); tick(4); chk(8'({pwr, cin}), 8'h00);
        rd(8'h50, v); chk(v & 8'h20, 8'h00);
        report_and_stop();
    end
endmodule // cmpc_top_tb

bind cmpc_top cmpc_properties u_prop (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .analog_gt_i,
    .analog_power_on_o, .pos_ref_select_o, .neg_use_channel_o, .neg_channel_o, .pin_buffer_enable_o,
    .pin_read_o, .global_irq_enable_i, .irq_ack_i, .irq_o, .capture_in_o, .capture_valid_o);
